// file: core/dbu_core.sv
// Debug breakpoint unit: debug registers, event capture and breakpoint logic
// Summary of operation
// RULE1 - Hold eight-bit thread selector for the debug register-read operation.
// RULE2 - Hold five-bit register number in bits 4:0; upper bits read zero.
// RULE3 - Record cause code 1..5 on debug interrupt; resets to zero.
// RULE4 - Record firing breakpoint index in bits 17:16, lowest index wins.
// RULE5 - Recorded index is zero for host request and debug-call causes.
// RULE6 - Record causing thread in bits 15:8, zero for host request.
// RULE7 - Capture data watch address or resource identifier into debug data.
// RULE8 - Eight-bit stop vector keeps marked threads from running after debug.
// RULE9 - Provide eight 32-bit scratch words for debug ROM and debugger.
// RULE10 - Scratch words are shared with the tile configuration space.
// RULE11 - Enabled breakpoint condition on program counter raises debug interrupt.
// RULE12 - Four independent breakpoints, each with address and control register.
// RULE13 - Per-thread enable mask in control bits 23:16, reset zero.
// RULE14 - Control bit 1 chooses equal or not-equal compare, reset zero.
// RULE15 - Control bit 0 enables the breakpoint, reset zero.
// RULE16 - Four 32-bit first addresses for the data watchpoints.
// RULE17 - Four 32-bit second addresses for the data watchpoints.
// RULE18 - All captured fields update in the same cycle as the interrupt.
`timescale 1ns/1ps
module dbu_core (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire dbu_pkg::dbu_req_s i_dbg_req,
  output logic [31:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire dbu_pkg::dbu_req_s i_cfg_req,
  output logic [31:0] o_cfg_rdata,
  output logic o_cfg_rvalid,
  input wire logic i_in_debug,
  input wire logic i_host_req,
  input wire logic i_debug_call_instruction,
  input wire logic [7:0] i_debug_call_instruction_thread,
  input wire logic i_pc_valid,
  input wire logic [31:0] i_pc,
  input wire logic [7:0] i_pc_thread,
  input wire logic [dbu_pkg::NUM_BP-1:0] i_dwatch_hit,
  input wire logic [7:0] i_dwatch_thread,
  input wire logic [31:0] i_dwatch_addr,
  input wire logic [dbu_pkg::NUM_BP-1:0] i_rwatch_hit,
  input wire logic [7:0] i_rwatch_thread,
  input wire logic [31:0] i_rwatch_res,
  output logic o_debug_int,
  output logic [dbu_pkg::THREADS-1:0] o_thread_stop,
  output logic [7:0] o_read_thread_select,
  output logic [4:0] o_read_register_number,
  output logic [dbu_pkg::NUM_BP-1:0][31:0] o_dwatch_first,
  output logic [dbu_pkg::NUM_BP-1:0][31:0] o_dwatch_second
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [7:0] thread_sel_reg;
  logic [4:0] reg_sel_reg;
  dbu_pkg::dbu_cause_s cause_reg;
  dbu_pkg::dbu_cause_s cause_next;
  logic [31:0] data_reg;
  logic [31:0] data_next;
  logic ev_take;
  logic int_reg;
  logic [dbu_pkg::THREADS-1:0] stop_reg;
  logic [dbu_pkg::NUM_SCRATCH-1:0][31:0] scratch_reg;
  logic [dbu_pkg::NUM_BP-1:0][31:0] ib_addr_reg;
  dbu_pkg::dbu_ibctrl_s [dbu_pkg::NUM_BP-1:0] ib_ctrl_reg;
  logic [dbu_pkg::NUM_BP-1:0][31:0] dw1_reg;
  logic [dbu_pkg::NUM_BP-1:0][31:0] dw2_reg;
  logic [dbu_pkg::NUM_BP-1:0] ib_hit;
  logic [31:0] rdata_next;
  logic [31:0] cfg_rdata_next;
  logic [31:0] rdata_reg;
  logic rvalid_reg;
  logic [31:0] cfg_rdata_reg;
  logic cfg_rvalid_reg;
  logic [7:0] dbg_off;
  logic [7:0] cfg_off;
  dbu_pkg::dbu_cause_s cause_wr;
  dbu_pkg::dbu_ibctrl_s ctrl_wr;
  dbu_pkg::dbu_regsel_s regsel_wr;

  // Write data seen through each register layout
  assign cause_wr = dbu_pkg::dbu_cause_s'(i_dbg_req.wdata);
  assign ctrl_wr = dbu_pkg::dbu_ibctrl_s'(i_dbg_req.wdata);
  assign regsel_wr = dbu_pkg::dbu_regsel_s'(i_dbg_req.wdata);

  function automatic logic in_block(input logic [7:0] num, input logic [7:0] base,
                                    input logic [7:0] count);
    return (num >= base) && ((num - base) < count);
  endfunction

  // Lowest set bit wins when several fire together
  function automatic logic [1:0] lowest(input logic [dbu_pkg::NUM_BP-1:0] v);
    logic [1:0] idx;
    idx = dbu_pkg::NO_INDEX;
    for (int i = dbu_pkg::NUM_BP - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction

  // ------------------------------------------------------------
  // Breakpoint comparators
  // ------------------------------------------------------------
  for (genvar b = 0; b < dbu_pkg::NUM_BP; b++) begin : g_ib
    dbu_ibreak u_ibreak (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_ctrl(ib_ctrl_reg[b]),
      .i_addr(ib_addr_reg[b]),
      .i_pc_valid(i_pc_valid),
      .i_pc(i_pc),
      .i_thread(i_pc_thread[dbu_pkg::TIDX_W-1:0]),
      .o_hit(ib_hit[b])
    );
  end

  // ------------------------------------------------------------
  // Event selection
  // ------------------------------------------------------------
  // Fixed priority: host, debug call, breakpoint, data watch, resource watch
  always_comb begin
    ev_take = 1'b0;
    cause_next = cause_reg;
    data_next = data_reg;
    if (!i_in_debug) begin
      if (i_host_req) begin
        ev_take = 1'b1;
        cause_next.cause = dbu_pkg::CAUSE_HOST; // RULE3
        cause_next.index = dbu_pkg::NO_INDEX; // RULE5
        cause_next.thread = dbu_pkg::NO_THREAD; // RULE6
      end else if (i_debug_call_instruction) begin
        ev_take = 1'b1;
        cause_next.cause = dbu_pkg::CAUSE_DEBUG_CALL_INSTRUCTION; // RULE3
        cause_next.index = dbu_pkg::NO_INDEX; // RULE5
        cause_next.thread = i_debug_call_instruction_thread; // RULE6
      end else if (|ib_hit) begin
        ev_take = 1'b1; // RULE11
        cause_next.cause = dbu_pkg::CAUSE_IBREAK;
        cause_next.index = lowest(ib_hit); // RULE4
        cause_next.thread = i_pc_thread;
      end else if (|i_dwatch_hit) begin
        ev_take = 1'b1;
        cause_next.cause = dbu_pkg::CAUSE_DWATCH;
        cause_next.index = lowest(i_dwatch_hit); // RULE4
        cause_next.thread = i_dwatch_thread;
        data_next = i_dwatch_addr; // RULE7
      end else if (|i_rwatch_hit) begin
        ev_take = 1'b1;
        cause_next.cause = dbu_pkg::CAUSE_RWATCH;
        cause_next.index = lowest(i_rwatch_hit); // RULE4
        cause_next.thread = i_rwatch_thread;
        data_next = i_rwatch_res; // RULE7
      end
    end
  end

  // ------------------------------------------------------------
  // Captured cause and data
  // ------------------------------------------------------------
  // Capture beats a software write in the same cycle, so no event is lost
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cause_reg <= dbu_pkg::dbu_cause_s'(dbu_pkg::RST_WORD);
      data_reg <= dbu_pkg::RST_WORD;
      int_reg <= 1'b0;
    end else begin
      int_reg <= ev_take;
      if (ev_take) begin
        cause_reg <= cause_next; // RULE18
        data_reg <= data_next; // RULE18
      end else if (i_dbg_req.wr) begin
        if (i_dbg_req.num == dbu_pkg::REG_CAUSE) begin
          cause_reg.cause <= cause_wr.cause;
          cause_reg.thread <= cause_wr.thread;
          cause_reg.index <= cause_wr.index;
        end
        if (i_dbg_req.num == dbu_pkg::REG_DATA) begin
          data_reg <= i_dbg_req.wdata;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Selectors and stop vector
  // ------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      thread_sel_reg <= dbu_pkg::RST_BYTE;
      reg_sel_reg <= dbu_pkg::RST_REG_SEL;
      stop_reg <= dbu_pkg::RST_BYTE;
    end else if (i_dbg_req.wr) begin
      if (i_dbg_req.num == dbu_pkg::REG_THREAD_SELECT) begin
        thread_sel_reg <= i_dbg_req.wdata[7:0]; // RULE1
      end
      if (i_dbg_req.num == dbu_pkg::REG_READ_SELECT) begin
        reg_sel_reg <= regsel_wr.reg_num; // RULE2
      end
      if (i_dbg_req.num == dbu_pkg::REG_STOP) begin
        stop_reg <= i_dbg_req.wdata[dbu_pkg::THREADS-1:0]; // RULE8
      end
    end
  end

  // ------------------------------------------------------------
  // Scratch words, shared with the configuration port
  // ------------------------------------------------------------
  // Debug port wins a same-word collision; the other write is dropped
  for (genvar k = 0; k < dbu_pkg::NUM_SCRATCH; k++) begin : g_scr
    always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
        scratch_reg[k] <= dbu_pkg::RST_WORD;
      end else if (i_dbg_req.wr && i_dbg_req.num == dbu_pkg::REG_SCRATCH + 8'(k)) begin
        scratch_reg[k] <= i_dbg_req.wdata; // RULE9
      end else if (i_cfg_req.wr && i_cfg_req.num == dbu_pkg::REG_SCRATCH + 8'(k)) begin
        scratch_reg[k] <= i_cfg_req.wdata; // RULE10
      end
    end
  end

  // ------------------------------------------------------------
  // Breakpoint and watchpoint address sets
  // ------------------------------------------------------------
  for (genvar b = 0; b < dbu_pkg::NUM_BP; b++) begin : g_bp
    always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
        ib_addr_reg[b] <= dbu_pkg::RST_WORD;
        ib_ctrl_reg[b] <= dbu_pkg::dbu_ibctrl_s'(dbu_pkg::RST_WORD);
        dw1_reg[b] <= dbu_pkg::RST_WORD;
        dw2_reg[b] <= dbu_pkg::RST_WORD;
      end else if (i_dbg_req.wr) begin
        if (i_dbg_req.num == dbu_pkg::REG_IB_ADDR + 8'(b)) begin
          ib_addr_reg[b] <= i_dbg_req.wdata; // RULE12
        end
        if (i_dbg_req.num == dbu_pkg::REG_IB_CTRL + 8'(b)) begin
          // Reserved bits are never stored
          ib_ctrl_reg[b].thread_mask <= ctrl_wr.thread_mask; // RULE12 RULE13
          ib_ctrl_reg[b].not_equal <= ctrl_wr.not_equal; // RULE14
          ib_ctrl_reg[b].enable <= ctrl_wr.enable; // RULE15
        end
        if (i_dbg_req.num == dbu_pkg::REG_DW_ADDR1 + 8'(b)) begin
          dw1_reg[b] <= i_dbg_req.wdata; // RULE16
        end
        if (i_dbg_req.num == dbu_pkg::REG_DW_ADDR2 + 8'(b)) begin
          dw2_reg[b] <= i_dbg_req.wdata; // RULE17
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Read paths
  // ------------------------------------------------------------
  always_comb begin
    dbg_off = 8'h0;
    rdata_next = dbu_pkg::RST_WORD;
    if (i_dbg_req.num == dbu_pkg::REG_THREAD_SELECT) begin
      rdata_next = 32'(thread_sel_reg);
    end else if (i_dbg_req.num == dbu_pkg::REG_READ_SELECT) begin
      rdata_next = 32'(reg_sel_reg); // RULE2
    end else if (i_dbg_req.num == dbu_pkg::REG_CAUSE) begin
      rdata_next = cause_reg;
    end else if (i_dbg_req.num == dbu_pkg::REG_DATA) begin
      rdata_next = data_reg;
    end else if (i_dbg_req.num == dbu_pkg::REG_STOP) begin
      rdata_next = 32'(stop_reg);
    end else if (in_block(i_dbg_req.num, dbu_pkg::REG_SCRATCH, 8'(dbu_pkg::NUM_SCRATCH))) begin
      dbg_off = i_dbg_req.num - dbu_pkg::REG_SCRATCH;
      rdata_next = scratch_reg[dbg_off[2:0]];
    end else if (in_block(i_dbg_req.num, dbu_pkg::REG_IB_ADDR, 8'(dbu_pkg::NUM_BP))) begin
      dbg_off = i_dbg_req.num - dbu_pkg::REG_IB_ADDR;
      rdata_next = ib_addr_reg[dbg_off[1:0]];
    end else if (in_block(i_dbg_req.num, dbu_pkg::REG_IB_CTRL, 8'(dbu_pkg::NUM_BP))) begin
      dbg_off = i_dbg_req.num - dbu_pkg::REG_IB_CTRL;
      rdata_next = ib_ctrl_reg[dbg_off[1:0]];
    end else if (in_block(i_dbg_req.num, dbu_pkg::REG_DW_ADDR1, 8'(dbu_pkg::NUM_BP))) begin
      dbg_off = i_dbg_req.num - dbu_pkg::REG_DW_ADDR1;
      rdata_next = dw1_reg[dbg_off[1:0]];
    end else if (in_block(i_dbg_req.num, dbu_pkg::REG_DW_ADDR2, 8'(dbu_pkg::NUM_BP))) begin
      dbg_off = i_dbg_req.num - dbu_pkg::REG_DW_ADDR2;
      rdata_next = dw2_reg[dbg_off[1:0]];
    end
  end

  always_comb begin
    cfg_off = i_cfg_req.num - dbu_pkg::REG_SCRATCH;
    cfg_rdata_next = dbu_pkg::RST_WORD;
    if (in_block(i_cfg_req.num, dbu_pkg::REG_SCRATCH, 8'(dbu_pkg::NUM_SCRATCH))) begin
      cfg_rdata_next = scratch_reg[cfg_off[2:0]]; // RULE10
    end
  end

  // Unmapped numbers answer zero so software never sees stale data
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= dbu_pkg::RST_WORD;
      rvalid_reg <= 1'b0;
      cfg_rdata_reg <= dbu_pkg::RST_WORD;
      cfg_rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= i_dbg_req.rd;
      cfg_rvalid_reg <= i_cfg_req.rd;
      if (i_dbg_req.rd) begin
        rdata_reg <= rdata_next;
      end
      if (i_cfg_req.rd) begin
        cfg_rdata_reg <= cfg_rdata_next;
      end
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_reg_rvalid = rvalid_reg;
  assign o_cfg_rdata = cfg_rdata_reg;
  assign o_cfg_rvalid = cfg_rvalid_reg;
  assign o_debug_int = int_reg;
  assign o_thread_stop = stop_reg;
  assign o_read_thread_select = thread_sel_reg;
  assign o_read_register_number = reg_sel_reg;
  assign o_dwatch_first = dw1_reg;
  assign o_dwatch_second = dw2_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence s_stop_write;
    i_dbg_req.wr && i_dbg_req.num == dbu_pkg::REG_STOP;
  endsequence

  sequence s_stop_read;
    i_dbg_req.rd && !i_dbg_req.wr && i_dbg_req.num == dbu_pkg::REG_STOP;
  endsequence

  a_host_cause: assert property ( // RULE3
    i_host_req && !i_in_debug |=> o_debug_int && cause_reg.cause == dbu_pkg::CAUSE_HOST)
    else $error("host request not recorded");

  a_host_zero: assert property ( // RULE6
    i_host_req && !i_in_debug |=> cause_reg.thread == 8'h0 && cause_reg.index == 2'h0)
    else $error("host request thread or index not zero");

  a_debug_call_instruction_index: assert property ( // RULE5
    i_debug_call_instruction && !i_host_req && !i_in_debug |=>
    cause_reg.cause == dbu_pkg::CAUSE_DEBUG_CALL_INSTRUCTION && cause_reg.index == 2'h0 &&
    cause_reg.thread == $past(i_debug_call_instruction_thread))
    else $error("debug call record wrong");

  a_ib_lowest: assert property ( // RULE4
    !i_in_debug && !i_host_req && !i_debug_call_instruction && ib_hit[1:0] == 2'b10 |=>
    cause_reg.cause == dbu_pkg::CAUSE_IBREAK && cause_reg.index == 2'h1)
    else $error("lowest breakpoint index not recorded");

  a_ib_takes_int: assert property ( // RULE11
    |ib_hit && !i_in_debug |=> o_debug_int)
    else $error("breakpoint hit gave no interrupt");

  a_dwatch_capture: assert property ( // RULE7
    !i_in_debug && !i_host_req && !i_debug_call_instruction && !(|ib_hit) && |i_dwatch_hit |=>
    data_reg == $past(i_dwatch_addr) && cause_reg.cause == dbu_pkg::CAUSE_DWATCH)
    else $error("data watch address not captured");

  a_int_consistent: assert property ( // RULE18
    o_debug_int |-> cause_reg == $past(cause_next) && data_reg == $past(data_next))
    else $error("capture not aligned with interrupt");

  a_stop_readback: assert property ( // RULE8
    s_stop_write ##1 !i_dbg_req.wr ##1 s_stop_read |=>
    o_reg_rvalid && o_reg_rdata == 32'($past(i_dbg_req.wdata[7:0], 3)))
    else $error("stop vector readback wrong");

  a_regsel_reserved: assert property ( // RULE2
    i_dbg_req.rd && i_dbg_req.num == dbu_pkg::REG_READ_SELECT |=>
    o_reg_rdata[31:5] == 27'h0 && o_reg_rdata[4:0] == o_read_register_number)
    else $error("register select readback wrong");

  a_scratch_shared: assert property ( // RULE10
    (i_cfg_req.wr && !i_dbg_req.wr &&
     in_block(i_cfg_req.num, dbu_pkg::REG_SCRATCH, 8'(dbu_pkg::NUM_SCRATCH)))
    ##1 (!i_dbg_req.wr && !i_cfg_req.wr)
    ##1 (i_dbg_req.rd && !i_dbg_req.wr && !i_cfg_req.wr &&
         i_dbg_req.num == $past(i_cfg_req.num, 2))
    |=> o_reg_rdata == $past(i_cfg_req.wdata, 3))
    else $error("scratch word not shared between ports");

  a_no_int_in_debug: assert property ( // RULE3
    i_in_debug |=> !o_debug_int)
    else $error("interrupt taken while in debug mode");

endmodule

// file: common/dbu_pkg.sv
// Package: register numbers, field layouts, cause codes and carriers of the debug unit
package dbu_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int THREADS = 8;
  localparam int TIDX_W = 3;
  localparam int NUM_BP = 4;
  localparam int NUM_SCRATCH = 8;
  localparam int WORD_W = 32;

  // ------------------------------------------------------------
  // Register numbers
  // ------------------------------------------------------------
  localparam logic [7:0] REG_THREAD_SELECT = 8'h13;
  localparam logic [7:0] REG_READ_SELECT = 8'h14;
  localparam logic [7:0] REG_CAUSE = 8'h15;
  localparam logic [7:0] REG_DATA = 8'h16;
  localparam logic [7:0] REG_STOP = 8'h18;
  localparam logic [7:0] REG_SCRATCH = 8'h20;
  localparam logic [7:0] REG_IB_ADDR = 8'h30;
  localparam logic [7:0] REG_IB_CTRL = 8'h40;
  localparam logic [7:0] REG_DW_ADDR1 = 8'h50;
  localparam logic [7:0] REG_DW_ADDR2 = 8'h60;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0;
  localparam logic [7:0] RST_BYTE = 8'h0;
  localparam logic [4:0] RST_REG_SEL = 5'h0;
  localparam logic [1:0] NO_INDEX = 2'h0;
  localparam logic [7:0] NO_THREAD = 8'h0;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    CAUSE_NONE = 3'b000,
    CAUSE_HOST = 3'b001,
    CAUSE_DEBUG_CALL_INSTRUCTION = 3'b010,
    CAUSE_IBREAK = 3'b011,
    CAUSE_DWATCH = 3'b100,
    CAUSE_RWATCH = 3'b101
  } dbu_cause_e;

  // Layout of the interrupt cause word
  typedef struct packed {
    logic [13:0] rsvd_hi;
    logic [1:0] index;
    logic [7:0] thread;
    logic [4:0] rsvd_lo;
    dbu_cause_e cause;
  } dbu_cause_s;

  // Layout of an instruction breakpoint control word
  typedef struct packed {
    logic [7:0] rsvd_hi;
    logic [7:0] thread_mask;
    logic [13:0] rsvd_lo;
    logic not_equal;
    logic enable;
  } dbu_ibctrl_s;

  // Layout of the read-register select word
  typedef struct packed {
    logic [26:0] rsvd;
    logic [4:0] reg_num;
  } dbu_regsel_s;

  // One register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] num;
    logic [31:0] wdata;
  } dbu_req_s;

endpackage

// file: core/dbu_ibreak.sv
// One instruction breakpoint comparator
`timescale 1ns/1ps
module dbu_ibreak (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire dbu_pkg::dbu_ibctrl_s i_ctrl,
  input wire logic [31:0] i_addr,
  input wire logic i_pc_valid,
  input wire logic [31:0] i_pc,
  input wire logic [dbu_pkg::TIDX_W-1:0] i_thread,
  output logic o_hit
);

  logic pc_match;
  logic cond_met;

  always_comb begin
    pc_match = (i_pc == i_addr);
    cond_met = i_ctrl.not_equal ? !pc_match : pc_match; // RULE14
    // RULE11 RULE13 RULE15
    o_hit = i_pc_valid && i_ctrl.enable && i_ctrl.thread_mask[i_thread] && cond_met;
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_hit_needs_enable: assert property ( // RULE15
    @(posedge i_clock) disable iff (!i_rst_n) o_hit |-> i_ctrl.enable && i_pc_valid)
    else $error("breakpoint fired while disabled");

  a_hit_thread_mask: assert property ( // RULE13
    @(posedge i_clock) disable iff (!i_rst_n) o_hit |-> i_ctrl.thread_mask[i_thread])
    else $error("breakpoint fired for masked thread");

  a_hit_condition: assert property ( // RULE14
    @(posedge i_clock) disable iff (!i_rst_n)
    o_hit |-> (i_ctrl.not_equal ? (i_pc != i_addr) : (i_pc == i_addr)))
    else $error("breakpoint condition not met");

endmodule

// file: tb/dbu_dbg_model.sv
// Debugger model: register accesses on the debug and config ports
`timescale 1ns/1ps
module dbu_dbg_model (
  input wire logic i_clock,
  output dbu_pkg::dbu_req_s o_dbg,
  output dbu_pkg::dbu_req_s o_cfg
);
  initial begin
    o_dbg = '0;
    o_cfg = '0;
  end
  // One-cycle strobe then idle, so back-to-back calls never collide
  task automatic acc(input logic cfg, input logic wr, input logic [7:0] n,
                     input logic [31:0] d);
    dbu_pkg::dbu_req_s r;
    r = '{wr: wr, rd: !wr, num: n, wdata: d};
    @(posedge i_clock);
    if (cfg) o_cfg <= r; else o_dbg <= r;
    @(posedge i_clock);
    o_cfg <= '0;
    o_dbg <= '0;
  endtask
endmodule

// file: tb/tb.sv
// Testbench of the debug breakpoint unit
`timescale 1ns/1ps
module tb;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  dbu_pkg::dbu_req_s dbg_req, cfg_req;
  logic [31:0] o_reg_rdata, o_cfg_rdata, pc, dw_addr, rw_res;
  logic o_reg_rvalid, o_cfg_rvalid, o_debug_int;
  logic in_debug, host_req, debug_call_instruction, pc_valid;
  logic [7:0] debug_call_instruction_thr, pc_thr, dw_thr, rw_thr, o_read_thread_select, o_thread_stop;
  logic [3:0] dw_hit, rw_hit;
  logic [4:0] o_read_register_number;
  logic [3:0][31:0] o_dwatch_first, o_dwatch_second;
  logic [31:0] q_reg[$], q_cfg[$];
  int error_cnt = 0;
  int n_tests = 0;
  int n_int = 0;
  int seed = 32'h33a4f8b4;
  always #4 i_clock = ~i_clock;
  dbu_dbg_model m (.i_clock(i_clock), .o_dbg(dbg_req), .o_cfg(cfg_req));
  dbu_core dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_dbg_req(dbg_req),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_cfg_req(cfg_req),
    .o_cfg_rdata(o_cfg_rdata), .o_cfg_rvalid(o_cfg_rvalid), .i_in_debug(in_debug),
    .i_host_req(host_req), .i_debug_call_instruction(debug_call_instruction), .i_debug_call_instruction_thread(debug_call_instruction_thr),
    .i_pc_valid(pc_valid), .i_pc(pc), .i_pc_thread(pc_thr), .i_dwatch_hit(dw_hit),
    .i_dwatch_thread(dw_thr), .i_dwatch_addr(dw_addr), .i_rwatch_hit(rw_hit),
    .i_rwatch_thread(rw_thr), .i_rwatch_res(rw_res), .o_debug_int(o_debug_int),
    .o_thread_stop(o_thread_stop), .o_read_thread_select(o_read_thread_select),
    .o_read_register_number(o_read_register_number),
    .o_dwatch_first(o_dwatch_first), .o_dwatch_second(o_dwatch_second));
  // ------------------------------------------------------------
  // Checking
  // ------------------------------------------------------------
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask
  always @(negedge i_clock) begin
    if (o_debug_int === 1'b1) n_int++;
    if (o_reg_rvalid === 1'b1)
      cmp("debug read", (q_reg.size() > 0) ? q_reg.pop_front() : 32'hx, o_reg_rdata);
    if (o_cfg_rvalid === 1'b1)
      cmp("config read", (q_cfg.size() > 0) ? q_cfg.pop_front() : 32'hx, o_cfg_rdata);
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge i_clock);
    error_cnt++;
    end_sim();
  end
  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  task automatic rd(input logic [7:0] n, input logic [31:0] e);
    q_reg.push_back(e);
    m.acc(1'b0, 1'b0, n, 32'h0);
  endtask
  task automatic wr(input logic [7:0] n, input logic [31:0] d);
    m.acc(1'b0, 1'b1, n, d);
  endtask
  function automatic logic [31:0] cw(input logic [2:0] c, input logic [1:0] idx,
                                     input logic [7:0] thr);
    return {14'h0, idx, thr, 5'h0, c};
  endfunction
  task automatic ev(input int kind, input logic [3:0] hits, input logic [7:0] thr,
                    input logic [31:0] val);
    @(posedge i_clock);
    case (kind)
      1: host_req <= 1'b1;
      2: begin debug_call_instruction <= 1'b1; debug_call_instruction_thr <= thr; end
      3: begin pc_valid <= 1'b1; pc <= val; pc_thr <= thr; end
      4: begin dw_hit <= hits; dw_thr <= thr; dw_addr <= val; end
      default: begin rw_hit <= hits; rw_thr <= thr; rw_res <= val; end
    endcase
    @(posedge i_clock);
    {host_req, debug_call_instruction, pc_valid, dw_hit, rw_hit} <= '0;
  endtask
  localparam logic [7:0] BASE [9] = '{8'h13, 8'h14, 8'h15, 8'h18, 8'h20, 8'h30, 8'h40,
                                      8'h50, 8'h60};
  localparam int CNT [9] = '{1, 1, 1, 1, 8, 4, 4, 4, 4};
  localparam logic [31:0] MSK [9] = '{32'hff, 32'h1f, 32'h3ff07, 32'hff, '1, '1,
                                      32'hff0003, '1, '1};
  initial begin : main
    logic [31:0] d, a, v;
    int i;
    {in_debug, host_req, debug_call_instruction, pc_valid, dw_hit, rw_hit} = '0;
    {debug_call_instruction_thr, pc_thr, dw_thr, rw_thr, pc, dw_addr, rw_res} = '0;
    repeat (10) @(posedge i_clock);
    i_rst_n <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      for (int j = 0; j < CNT[k]; j++) begin
        d = $random(seed);
        rd(BASE[k] + 8'(j), 32'h0);
        wr(BASE[k] + 8'(j), d);
        rd(BASE[k] + 8'(j), d & MSK[k]);
      end
    end
    for (int j = 0; j < 4; j++) begin
      a = $random(seed);
      wr(8'h50 + 8'(j), a);
      wr(8'h60 + 8'(j), ~a);
      @(negedge i_clock);
      cmp("first addr", a, o_dwatch_first[j]);
      cmp("second addr", ~a, o_dwatch_second[j]);
    end
    wr(8'h13, 32'h5c);
    wr(8'h14, 32'hea);
    @(negedge i_clock);
    cmp("thread select", 32'h5c, 32'(o_read_thread_select));
    cmp("register number", 32'h0a, 32'(o_read_register_number));
    wr(8'h17, '1);
    rd(8'h17, 32'h0);
    d = $random(seed);
    m.acc(1'b1, 1'b1, 8'h25, d);
    rd(8'h25, d);
    wr(8'h22, ~d);
    q_cfg.push_back(~d);
    m.acc(1'b1, 1'b0, 8'h22, 32'h0);
    wr(8'h16, 32'h5a5a0016);
    ev(1, 4'h0, 8'h07, 32'h0);
    rd(8'h15, cw(3'h1, 2'h0, 8'h00));
    rd(8'h16, 32'h5a5a0016);
    ev(2, 4'h0, 8'h05, 32'h0);
    rd(8'h15, cw(3'h2, 2'h0, 8'h05));
    a = $random(seed);
    wr(8'h30, a);
    wr(8'h31, a);
    wr(8'h32, ~a);
    wr(8'h40, 32'h00040001);
    wr(8'h41, 32'h00080001);
    wr(8'h42, 32'h00080003);
    wr(8'h43, 32'h0);
    ev(3, 4'h0, 8'h03, a);
    rd(8'h15, cw(3'h3, 2'h1, 8'h03));
    wr(8'h41, 32'h00080000);
    ev(3, 4'h0, 8'h03, a);
    rd(8'h15, cw(3'h3, 2'h2, 8'h03));
    ev(3, 4'h0, 8'h03, ~a);
    rd(8'h15, cw(3'h3, 2'h2, 8'h03));
    v = $random(seed);
    ev(4, 4'b1010, 8'h06, v);
    rd(8'h15, cw(3'h4, 2'h1, 8'h06));
    rd(8'h16, v);
    ev(5, 4'b1000, 8'h04, ~v);
    rd(8'h15, cw(3'h5, 2'h3, 8'h04));
    rd(8'h16, ~v);
    in_debug <= 1'b1;
    ev(1, 4'h0, 8'h00, 32'h0);
    rd(8'h15, cw(3'h5, 2'h3, 8'h04));
    wr(8'h18, 32'h81);
    @(negedge i_clock);
    cmp("thread stop", 32'h81, {24'h0, o_thread_stop});
    for (i = 0; i < 20 && (q_reg.size() + q_cfg.size()) > 0; i++) @(posedge i_clock);
    repeat (2) @(posedge i_clock);
    cmp("pending reads", 32'h0, 32'(q_reg.size() + q_cfg.size()));
    cmp("interrupt count", 32'd6, 32'(n_int));
    end_sim();
  end
endmodule
